// [core/pcc_pkg.sv]
// Constants, register map and timing for the PLL clock control block
//
// Notes on behaviour
// - Lock output is active while locked; its active level is configurable.
// - Lock qualification counts a programmable 16 to 256 cycles before lock.
// - Lock output drops at once when the locked condition is lost.
// - Lock indicator may be routed onto the user programmable pin.
// - Fine skew mode: four dividers divide by 2, 4, 8 and 16.
// - Coarse skew mode: four dividers divide by 4, 8, 16 and 32.
// - Any of the four divider outputs may be chosen as loop feedback.
// - Loop mode: each divider runs from the oscillator, output ref*fb/div.
// - Bypass: selected reference feeds the dividers directly.
// - In bypass there is no lock detection and no phase skew.
// - Bypass comes from a user pin or from a register setting.
// - Feedback is internal from a divider or external from a bank input.
// - Internal feedback: only phase skew applies to the feedback path.
// - External feedback: both phase and time skew apply to feedback.
// - Exactly one of the two reference inputs is passed to the loop.
// - Reference choice comes from a user pin or from a register setting.
// - Serial clock held low 25 to 35 ms aborts the serial transfer.
// - Coarse mode inserts an extra divide by two before all dividers.
package pcc_pkg;
	////////////////////////////////////////////////////////////////////////
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_FBSEL = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_LOCKLEN = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_SKEW = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;
	// Control register bits
	localparam int CTL_BYP_VAL = 0;
	localparam int CTL_BYP_REG = 1;
	localparam int CTL_SRC_VAL = 2;
	localparam int CTL_SRC_REG = 3;
	localparam int CTL_COARSE = 4;
	localparam int CTL_FB_EXT = 5;
	localparam int CTL_POL_HIGH = 6;
	localparam int CTL_LOCK_USER = 7;
	// Status register bits
	localparam int ST_LOCKED = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_LOOP_IN = 2;
	localparam int ST_BYPASS = 3;
	localparam int ST_SOURCE = 4;
	// Skew register fields
	localparam int SKEW_W = 4;
	localparam int SKEW_PH_LSB = 0;
	localparam int SKEW_TM_LSB = 4;
	localparam int FB_SEL_W = 2;
	localparam int NUM_DIV = 4;
	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h40;
	localparam logic [FB_SEL_W-1:0] FBSEL_RST = 2'h0;
	localparam logic [DATA_W-1:0] LOCKLEN_RST = 8'h0F;
	localparam logic [DATA_W-1:0] SKEW_RST = 8'h00;
	// Lock length register holds cycles minus one: 16 to 256 cycles
	localparam int LOCK_MIN = 16;
	localparam int LOCK_MAX = 256;
	localparam logic [DATA_W-1:0] LOCKLEN_MIN = DATA_W'(LOCK_MIN - 1);
	// Divider counter width fits the largest half period (coarse /32)
	localparam int DIV_CNT_W = 5;
	// Timing
	localparam int CLK_KHZ = 125000;
	localparam int TMO_MIN_MS = 25;
	localparam int TMO_MAX_MS = 35;
	localparam int TMO_CYC = TMO_MIN_MS * CLK_KHZ;
	localparam int TMO_CNT_W = 22;
	localparam int POR_WAIT_MS = 500;
	// Pin synchroniser lane positions
	localparam int NUM_PINS = 8;
	localparam int PIN_PRI = 0;
	localparam int PIN_SEC = 1;
	localparam int PIN_VCO = 2;
	localparam int PIN_EXTFB = 3;
	localparam int PIN_LOCK = 4;
	localparam int PIN_BYP = 5;
	localparam int PIN_SRC = 6;
	localparam int PIN_SCL = 7;
endpackage : pcc_pkg

// [core/pcc_div_if.sv]
// Link between the control core and one output divider
`timescale 1ns/1ps
`default_nettype none
interface pcc_div_if;
	logic tick;
	logic coarse;
	logic out;
	modport src (output tick, output coarse, input out);
	modport div (input tick, input coarse, output out);
endinterface : pcc_div_if
`default_nettype wire

// [core/pcc_divider.sv]
// One output divider, ratio 2^(IDX+1), doubled in coarse mode
`timescale 1ns/1ps
`default_nettype none
module pcc_divider
	import pcc_pkg::*;
#(
	parameter int IDX = 0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Divider link
	pcc_div_if.div dv
);
	logic [DIV_CNT_W-1:0] cnt;
	logic [DIV_CNT_W-1:0] next_cnt;
	logic [DIV_CNT_W-1:0] half_m1;
	logic out;
	logic next_out;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		// Coarse doubles the half period: the extra divide by two
		if (dv.coarse) begin
			half_m1 = DIV_CNT_W'((1 << (IDX + 1)) - 1);
		end else begin
			half_m1 = DIV_CNT_W'((1 << IDX) - 1);
		end
		next_cnt = cnt;
		next_out = out;
		if (dv.tick) begin
			// >= so a mode change mid-count cannot stall the divider
			if (cnt >= half_m1) begin
				next_cnt = '0;
				next_out = !out;
			end else begin
				next_cnt = cnt + DIV_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt <= '0;
			out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			out <= next_out;
		end
	end

	assign dv.out = out;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_div_half_period: assert property (
		$changed(out) |-> $past(dv.tick) && ($past(cnt) >= $past(half_m1)))
		else $error("divider toggled before its half period");
	// A coarse toggle must come after the full doubled half period
	a_div_coarse_len: assert property (
		$changed(out) && $past(dv.coarse)
		|-> $past(cnt) == DIV_CNT_W'((2 << IDX) - 1))
		else $error("coarse half period wrong");
endmodule : pcc_divider
`default_nettype wire

// [core/pcc_clock_control.sv]
// PLL clock control: reference select, bypass, dividers, feedback, lock
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_control
	import pcc_pkg::*;
#(
	parameter int TIMEOUT_CYC = TMO_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// Clock and status pins
	input wire logic i_primary_clock_in,
	input wire logic i_secondary_clock_in,
	input wire logic i_vco_clk,
	input wire logic i_ext_feedback,
	input wire logic i_loop_locked,
	// User control pins
	input wire logic i_bypass_pin,
	input wire logic i_source_choice_pin,
	// Serial control port clock line
	input wire logic i_scl,
	// Loop side outputs
	output logic o_ref_to_loop,
	output logic o_feedback,
	output logic [SKEW_W-1:0] o_fb_phase_skew,
	output logic [SKEW_W-1:0] o_fb_time_skew,
	output logic o_bypass,
	// Divider outputs
	output logic [NUM_DIV-1:0] o_div_out,
	// Lock indicator and user pin
	output logic o_lock,
	output logic o_user_pin,
	// Serial port abort
	output logic o_serial_abort
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	logic [NUM_PINS-1:0] pin_s1;
	logic [NUM_PINS-1:0] pin_s2;
	logic src_prev;
	logic vco_prev;
	logic next_src_prev;
	logic next_vco_prev;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {i_scl, i_source_choice_pin, i_bypass_pin,
				i_loop_locked, i_ext_feedback, i_vco_clk,
				i_secondary_clock_in, i_primary_clock_in};
			pin_s2 <= pin_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] next_ctrl;
	logic [FB_SEL_W-1:0] fb_sel;
	logic [FB_SEL_W-1:0] next_fb_sel;
	logic [DATA_W-1:0] lock_len;
	logic [DATA_W-1:0] next_lock_len;
	logic [DATA_W-1:0] skew;
	logic [DATA_W-1:0] next_skew;
	logic tmo_flag;
	logic next_tmo_flag;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] status;
	logic locked;
	logic tmo_hit;
	logic bypass_eff;
	logic source_choice;

	// Pin or register source for bypass and reference choice
	assign bypass_eff = ctrl[CTL_BYP_REG] ? ctrl[CTL_BYP_VAL]
		: pin_s2[PIN_BYP];
	assign source_choice = ctrl[CTL_SRC_REG] ? ctrl[CTL_SRC_VAL]
		: pin_s2[PIN_SRC];

	always_comb begin
		status = '0;
		status[ST_LOCKED] = locked;
		status[ST_TIMEOUT] = tmo_flag;
		status[ST_LOOP_IN] = pin_s2[PIN_LOCK];
		status[ST_BYPASS] = bypass_eff;
		status[ST_SOURCE] = source_choice;
	end

	always_comb begin
		next_ctrl = ctrl;
		next_fb_sel = fb_sel;
		next_lock_len = lock_len;
		next_skew = skew;
		next_tmo_flag = tmo_flag;
		next_rdata = '0;
		if (i_wr) begin
			case (i_addr)
				ADDR_CTRL: begin
					next_ctrl = i_wdata;
				end
				ADDR_FBSEL: begin
					next_fb_sel = i_wdata[FB_SEL_W-1:0];
				end
				ADDR_LOCKLEN: begin
					// Below 16 cycles is not allowed; clamp up
					if (i_wdata < LOCKLEN_MIN) begin
						next_lock_len = LOCKLEN_MIN;
					end else begin
						next_lock_len = i_wdata;
					end
				end
				ADDR_SKEW: begin
					next_skew = i_wdata;
				end
				ADDR_STATUS: begin
					if (i_wdata[ST_TIMEOUT]) begin
						next_tmo_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// A new timeout beats a clear in the same cycle
		if (tmo_hit) begin
			next_tmo_flag = 1'b1;
		end
		if (i_rd) begin
			case (i_addr)
				ADDR_CTRL: next_rdata = ctrl;
				ADDR_FBSEL: next_rdata = DATA_W'(fb_sel);
				ADDR_LOCKLEN: next_rdata = lock_len;
				ADDR_SKEW: next_rdata = skew;
				ADDR_STATUS: next_rdata = status;
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl <= CTRL_RST;
			fb_sel <= FBSEL_RST;
			lock_len <= LOCKLEN_RST;
			skew <= SKEW_RST;
			tmo_flag <= 1'b0;
			o_rdata <= '0;
		end else begin
			ctrl <= next_ctrl;
			fb_sel <= next_fb_sel;
			lock_len <= next_lock_len;
			skew <= next_skew;
			tmo_flag <= next_tmo_flag;
			o_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider bank. Sampling limits usable clock rates to well below
	// half of i_clk; the real high-speed path is analog.
	logic ref_sel;
	logic div_src;
	logic div_tick;
	logic [NUM_DIV-1:0] div_q;

	// Exactly one reference reaches the loop
	assign ref_sel = source_choice ? pin_s2[PIN_SEC] : pin_s2[PIN_PRI];
	// Bypass feeds the reference, otherwise the oscillator
	assign div_src = bypass_eff ? ref_sel : pin_s2[PIN_VCO];
	assign div_tick = div_src && !(bypass_eff ? src_prev : vco_prev);

	always_comb begin
		next_src_prev = ref_sel;
		next_vco_prev = pin_s2[PIN_VCO];
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			src_prev <= 1'b0;
			vco_prev <= 1'b0;
		end else begin
			src_prev <= next_src_prev;
			vco_prev <= next_vco_prev;
		end
	end

	pcc_div_if div_link [NUM_DIV] ();

	for (genvar k = 0; k < NUM_DIV; k++) begin : g_div
		assign div_link[k].tick = div_tick;
		assign div_link[k].coarse = ctrl[CTL_COARSE];
		assign div_q[k] = div_link[k].out;
		pcc_divider #(.IDX(k)) u_div (
			.i_clk(i_clk),
			.i_reset(i_reset),
			.dv(div_link[k])
		);
	end

	assign o_div_out = div_q;

	////////////////////////////////////////////////////////////////////////
	// Lock qualification
	logic [DATA_W-1:0] qual_cnt;
	logic [DATA_W-1:0] next_qual_cnt;
	logic next_locked;
	logic lock_in;

	// No lock detection while bypassed
	assign lock_in = pin_s2[PIN_LOCK] && !bypass_eff;

	always_comb begin
		next_qual_cnt = qual_cnt;
		next_locked = locked;
		if (!lock_in) begin
			// Loss drops lock and restarts the count
			next_qual_cnt = '0;
			next_locked = 1'b0;
		end else if (!locked) begin
			if (qual_cnt >= lock_len) begin
				next_locked = 1'b1;
			end else begin
				next_qual_cnt = qual_cnt + DATA_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			qual_cnt <= '0;
			locked <= 1'b0;
		end else begin
			qual_cnt <= next_qual_cnt;
			locked <= next_locked;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial clock low timeout
	logic [TMO_CNT_W-1:0] tmo_cnt;
	logic [TMO_CNT_W-1:0] next_tmo_cnt;

	assign tmo_hit = !pin_s2[PIN_SCL]
		&& (tmo_cnt == TMO_CNT_W'(TIMEOUT_CYC - 1));

	always_comb begin
		next_tmo_cnt = tmo_cnt;
		if (pin_s2[PIN_SCL]) begin
			next_tmo_cnt = '0;
		end else if (tmo_cnt < TMO_CNT_W'(TIMEOUT_CYC)) begin
			// Saturate so one long low gives a single abort
			next_tmo_cnt = tmo_cnt + TMO_CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tmo_cnt <= '0;
		end else begin
			tmo_cnt <= next_tmo_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	logic next_lock_out;
	logic next_feedback;
	logic [SKEW_W-1:0] next_ph_skew;
	logic [SKEW_W-1:0] next_tm_skew;

	always_comb begin
		// Active level chosen by configuration
		next_lock_out = ctrl[CTL_POL_HIGH] ? next_locked : !next_locked;
		// Internal divider or external bank feedback
		next_feedback = ctrl[CTL_FB_EXT] ? pin_s2[PIN_EXTFB]
			: div_q[fb_sel];
		// Phase skew only exists with the loop running
		next_ph_skew = bypass_eff ? '0
			: skew[SKEW_PH_LSB +: SKEW_W];
		// Time skew on feedback only with external feedback
		next_tm_skew = ctrl[CTL_FB_EXT] ? skew[SKEW_TM_LSB +: SKEW_W]
			: '0;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_lock <= 1'b0;
			o_user_pin <= 1'b0;
			o_feedback <= 1'b0;
			o_ref_to_loop <= 1'b0;
			o_fb_phase_skew <= '0;
			o_fb_time_skew <= '0;
			o_bypass <= 1'b0;
			o_serial_abort <= 1'b0;
		end else begin
			o_lock <= next_lock_out;
			// User pin carries lock when routed there
			o_user_pin <= ctrl[CTL_LOCK_USER] && next_lock_out;
			o_feedback <= next_feedback;
			o_ref_to_loop <= ref_sel;
			o_fb_phase_skew <= next_ph_skew;
			o_fb_time_skew <= next_tm_skew;
			o_bypass <= bypass_eff;
			o_serial_abort <= tmo_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_lost;
		!lock_in;
	endsequence
	sequence s_qual_done;
		lock_in && !locked && (qual_cnt >= lock_len);
	endsequence

	a_lock_drop_now: assert property (s_lost |=> !locked)
		else $error("lock held after loss");
	a_lock_qual_len: assert property (
		$rose(locked) |-> $past(qual_cnt) == $past(lock_len))
		else $error("lock raised after wrong count");
	a_lock_set_now: assert property (s_qual_done |=> locked)
		else $error("qualified lock not raised");
	a_lock_pol_out: assert property (
		o_lock == ($past(ctrl[CTL_POL_HIGH]) ? locked : !locked))
		else $error("lock output level wrong");
	a_bypass_no_lock: assert property (
		bypass_eff |=> !locked && o_fb_phase_skew == '0)
		else $error("lock or phase skew active in bypass");
	a_int_fb_time: assert property (
		!ctrl[CTL_FB_EXT] |=> o_fb_time_skew == '0)
		else $error("time skew on internal feedback");
	a_fb_source_sel: assert property (
		o_feedback == ($past(ctrl[CTL_FB_EXT]) ? $past(pin_s2[PIN_EXTFB])
			: $past(div_q[fb_sel])))
		else $error("feedback source wrong");
	a_ref_one_src: assert property (
		o_ref_to_loop == $past(source_choice ? pin_s2[PIN_SEC]
			: pin_s2[PIN_PRI]))
		else $error("reference select wrong");
	a_scl_timeout: assert property (
		!pin_s2[PIN_SCL] && tmo_cnt == TMO_CNT_W'(TIMEOUT_CYC - 1)
		|=> o_serial_abort ##1 !o_serial_abort)
		else $error("timeout abort pulse wrong");
	a_user_route: assert property (
		o_user_pin == ($past(ctrl[CTL_LOCK_USER]) && o_lock))
		else $error("user pin routing wrong");
endmodule : pcc_clock_control
`default_nettype wire

// [bench/pcc_clock_source.sv]
// Partner model: reference clocks, oscillator, bank feedback, serial host
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_source #(
	parameter int PRI_HALF = 8,
	parameter int SEC_HALF = 12,
	parameter int VCO_HALF = 4,
	parameter int EXT_HALF = 10
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Serial host request
	input wire logic i_hold_scl_low,
	// Clock lines
	output logic o_primary,
	output logic o_secondary,
	output logic o_vco,
	output logic o_ext_fb,
	output logic o_scl
);
	int cnt;
	// No loop reset pulse is made here; one would last 10 us or more
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Oscillator kept slower than the sampling clock and inside its band
	always_comb begin
		o_primary = ((cnt / PRI_HALF) % 2) == 1;
		o_secondary = ((cnt / SEC_HALF) % 2) == 1;
		o_vco = ((cnt / VCO_HALF) % 2) == 1;
		o_ext_fb = ((cnt / EXT_HALF) % 2) == 1;
	end
	// Line is pulled up; the host pulls it low only when asked, never early
	assign o_scl = !i_hold_scl_low;
endmodule : pcc_clock_source
`default_nettype wire

// [bench/pcc_clock_control_tb.sv]
// Self-checking testbench for the PLL clock control block
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_control_tb;
	import pcc_pkg::*;
	localparam int TMO = 20;
	localparam int LIMIT = 40000;
	logic i_clk, i_reset, i_wr, i_rd, o_lock, o_user_pin, o_serial_abort;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata, rd;
	logic pri, sec, vco, extfb, scl, hold, locked_in, byp_pin, src_pin;
	logic o_ref_to_loop, o_feedback, o_bypass;
	logic [SKEW_W-1:0] o_fb_phase_skew, o_fb_time_skew;
	logic [NUM_DIV-1:0] o_div_out;
	logic [9:0] mon;
	int failures, checks_done, cycles, n;
	assign mon = {extfb, vco, sec, pri, o_feedback, o_ref_to_loop, o_div_out};
	////////////////////////////////////////////////////////////////////////
	pcc_clock_control #(.TIMEOUT_CYC(TMO)) u_pcc_clock_control (
		.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_primary_clock_in(pri), .i_secondary_clock_in(sec),
		.i_vco_clk(vco), .i_ext_feedback(extfb),
		.i_loop_locked(locked_in), .i_bypass_pin(byp_pin),
		.i_source_choice_pin(src_pin), .i_scl(scl),
		.o_ref_to_loop(o_ref_to_loop), .o_feedback(o_feedback),
		.o_fb_phase_skew(o_fb_phase_skew), .o_fb_time_skew(o_fb_time_skew),
		.o_bypass(o_bypass), .o_div_out(o_div_out), .o_lock(o_lock),
		.o_user_pin(o_user_pin), .o_serial_abort(o_serial_abort));
	pcc_clock_source u_pcc_clock_source (
		.i_clk(i_clk), .i_reset(i_reset), .i_hold_scl_low(hold),
		.o_primary(pri), .o_secondary(sec), .o_vco(vco),
		.o_ext_fb(extfb), .o_scl(scl));
	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task chk_val(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask : chk_val
	task chk_cnt(input int got, input int exp, input string m);
		checks_done++;
		if (got != exp) begin
			failures++;
			$display("unexpected at %0t: %s got %0d", $time, m, got);
		end
	endtask : chk_cnt
	task reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : reg_wr
	task reg_rd(input logic [ADDR_W-1:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rd = o_rdata;
	endtask : reg_rd
	// Edges of mon[r] (cycles if r < 0) within one period of mon[s]
	task meas(input int s, input int r, output int cnt);
		int ph, k;
		logic ps, pr;
		ph = 0;
		k = 0;
		cnt = 0;
		ps = mon[s];
		pr = 1'b1;
		while (ph < 2 && k < 3000) begin
			@(posedge i_clk);
			#1 k++;
			if (ph == 1 && (r < 0 || (mon[r] === 1'b1 && !pr)))
				cnt++;
			if (mon[s] === 1'b1 && !ps)
				ph++;
			ps = mon[s];
			pr = (r < 0) ? 1'b1 : mon[r];
		end
	endtask : meas
	task idle(input int c);
		repeat (c) @(posedge i_clk);
		#1;
	endtask : idle
	////////////////////////////////////////////////////////////////////////
	task test_reset;
		logic [ADDR_W-1:0] a[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		logic [7:0] e[5] = '{8'h40, 8'h00, 8'h0F, 8'h00, 8'h00};
		reg_wr(3'h7, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			reg_rd(a[i]);
			chk_val(rd, e[i], "reset value");
		end
		idle(1);
		chk_val(o_rdata, 8'h00, "read data after slot");
		$display("test reset done");
	endtask : test_reset
	task lock_run(input logic [7:0] len, input int exp_n);
		reg_wr(ADDR_LOCKLEN, len);
		@(posedge i_clk);
		locked_in <= 1'b1;
		n = 0;
		while (o_lock !== 1'b1 && n < 400) begin
			idle(1);
			n++;
		end
		chk_cnt(n, exp_n, "lock qualify cycles");
		reg_rd(ADDR_STATUS);
		chk_val(rd & 8'h05, 8'h05, "status locked and input");
		@(posedge i_clk);
		locked_in <= 1'b0;
		idle(2);
		chk_val(o_lock, 1'b1, "lock held before loss seen");
		idle(1);
		chk_val(o_lock, 1'b0, "lock drop");
	endtask : lock_run
	task test_lock;
		reg_wr(ADDR_LOCKLEN, 8'h05);
		reg_rd(ADDR_LOCKLEN);
		chk_val(rd, 8'h0F, "lock length clamp");
		@(posedge i_clk);
		locked_in <= 1'b1;
		repeat (12) @(posedge i_clk);
		locked_in <= 1'b0;
		idle(6);
		chk_val(o_lock, 1'b0, "partial qualify");
		lock_run(8'h0F, 18);
		lock_run(8'hFF, 258);
		$display("test lock done");
	endtask : test_lock
	task test_bypass;
		reg_wr(ADDR_CTRL, 8'h83);
		@(posedge i_clk);
		locked_in <= 1'b1;
		idle(270);
		chk_val(o_lock, 1'b1, "no lock in bypass, low active");
		chk_val(o_user_pin, 1'b1, "user pin follows lock");
		chk_val(o_bypass, 1'b1, "register bypass");
		reg_wr(ADDR_CTRL, 8'h80);
		idle(270);
		chk_val(o_lock, 1'b0, "low active lock");
		chk_val(o_user_pin, 1'b0, "user pin lock");
		reg_wr(ADDR_CTRL, 8'h00);
		locked_in <= 1'b0;
		byp_pin <= 1'b1;
		idle(8);
		chk_val(o_bypass, 1'b1, "pin bypass");
		chk_val(o_user_pin, 1'b0, "user pin unrouted");
		reg_rd(ADDR_STATUS);
		chk_val(rd[ST_BYPASS], 1'b1, "status bypass");
		@(posedge i_clk);
		byp_pin <= 1'b0;
		$display("test bypass done");
	endtask : test_bypass
	task test_div;
		for (int c = 0; c < 2; c++) begin
			reg_wr(ADDR_CTRL, c ? 8'h53 : 8'h43);
			for (int k = 0; k < NUM_DIV; k++) begin
				meas(k, 6, n);
				meas(k, 6, n);
				chk_cnt(n, 2 ** (k + 1 + c), "divider ratio");
			end
		end
		$display("test dividers done");
	endtask : test_div
	task test_fb;
		reg_wr(ADDR_CTRL, 8'h40);
		reg_wr(ADDR_SKEW, 8'hA5);
		for (int k = 0; k < NUM_DIV; k++) begin
			reg_wr(ADDR_FBSEL, k[7:0]);
			meas(5, 8, n);
			meas(5, 8, n);
			chk_cnt(n, 2 ** (k + 1), "feedback ratio");
		end
		chk_val({4'h0, o_fb_phase_skew}, 8'h05, "internal phase skew");
		chk_val({4'h0, o_fb_time_skew}, 8'h00, "internal time skew");
		reg_wr(ADDR_CTRL, 8'h60);
		meas(5, 9, n);
		meas(5, 9, n);
		chk_cnt(n, 1, "external feedback");
		chk_val({4'h0, o_fb_time_skew}, 8'h0A, "external time skew");
		chk_val({4'h0, o_fb_phase_skew}, 8'h05, "external phase skew");
		reg_wr(ADDR_CTRL, 8'h43);
		idle(4);
		chk_val({4'h0, o_fb_phase_skew}, 8'h00, "bypass phase skew");
		$display("test feedback done");
	endtask : test_fb
	task test_src;
		int exp_p[3] = '{24, 24, 16};
		logic [7:0] ctl[3] = '{8'h4C, 8'h40, 8'h40};
		for (int i = 0; i < 3; i++) begin
			reg_wr(ADDR_CTRL, ctl[i]);
			src_pin <= (i == 1);
			meas(4, -1, n);
			meas(4, -1, n);
			chk_cnt(n, exp_p[i], "reference period");
		end
		$display("test source done");
	endtask : test_src
	task test_tmo;
		@(posedge i_clk);
		hold <= 1'b1;
		n = 0;
		repeat (TMO + 30) begin
			idle(1);
			n += (o_serial_abort === 1'b1);
		end
		chk_cnt(n, 1, "one abort pulse");
		reg_rd(ADDR_STATUS);
		chk_val(rd[ST_TIMEOUT], 1'b1, "timeout flag");
		@(posedge i_clk);
		hold <= 1'b0;
		reg_wr(ADDR_STATUS, 8'h02);
		reg_rd(ADDR_STATUS);
		chk_val(rd[ST_TIMEOUT], 1'b0, "timeout cleared");
		// Clear lands in the very cycle of a new timeout: the set wins
		@(posedge i_clk);
		hold <= 1'b1;
		repeat (TMO) @(posedge i_clk);
		reg_wr(ADDR_STATUS, 8'h02);
		reg_rd(ADDR_STATUS);
		chk_val(rd[ST_TIMEOUT], 1'b1, "timeout beats clear");
		@(posedge i_clk);
		hold <= 1'b0;
		$display("test timeout done");
	endtask : test_tmo
	////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Hang guard, ceiling well above the expected run
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			$display("unexpected at %0t: run too long", $time);
			give_verdict();
		end
	end
	initial begin
		{i_reset, i_wr, i_rd, hold, locked_in, byp_pin, src_pin} = 7'h40;
		i_addr = 3'h0;
		i_wdata = 8'h00;
		{failures, checks_done, cycles} = 0;
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		test_reset();
		test_lock();
		test_bypass();
		test_div();
		test_fb();
		test_src();
		test_tmo();
		give_verdict();
	end
endmodule : pcc_clock_control_tb
`default_nettype wire
